// ### timer_master_slave_sync_bench.sv
// Self-checking bench for the timer master/slave synchronisation block.
// Assumes a 40 MHz clock; a master model drives internal trigger zero.
`timescale 1ns/100ps
module timer_master_slave_sync_bench
    import tms_pkg::*;
;
    typedef struct packed {logic [2:0] mos; logic [3:0] cref; logic [2:0] ts; logic exp;} tms_row_t;
    tms_row_t rows [7] = '{'{3'h4, 4'h1, 3'h1, 1'b1}, '{3'h5, 4'h2, 3'h2, 1'b1}, '{3'h6, 4'hB, 3'h3, 1'b0},
        '{3'h7, 4'h8, 3'h4, 1'b1}, '{3'h4, 4'hE, 3'h5, 1'b0}, '{3'h1, 4'h0, 3'h6, 1'b1}, '{3'h0, 4'hF, 3'h7, 1'b0}};
    logic clk = 1'b0, rst_b = 1'b0, msb = 1'b0, halted = 1'b0, freeze = 1'b0;
    logic en_set = 1'b0, en_clr = 1'b0, ug = 1'b0, cwr = 1'b0, fclr = 1'b0, m_gate = 1'b0, m_fire = 1'b0;
    logic [2:0] mos = 3'h0, ts = 3'h0, sm = 3'h0;
    logic [15:0] psc = 16'h0000, arr = 16'hFFFF, cwd = 16'h0000, c;
    logic [7:0] src = 8'h00, m_cnt = 8'h00;
    logic [3:0] cref = 4'h0;
    logic trg, en, run, flag, upd, internal_trigger_zero, m_busy;
    logic [15:0] cnt;
    int err_count = 0, compares = 0, cycles = 0, d0, d1, nu;
    always #12.5 clk = ~clk;
    tms_timer_sync i_tms_timer_sync (.CORE_CLK(clk), .RST_B(rst_b), .MASTER_OUTPUT_SELECT(mos),
        .TRIGGER_SOURCE_SELECT(ts), .SLAVE_MODE_SELECT(sm), .MASTER_SLAVE_BIT(msb), .PRESCALE_DIV(psc),
        .AUTO_RELOAD(arr), .COUNTER_ENABLE_SET(en_set), .COUNTER_ENABLE_CLEAR(en_clr),
        .UPDATE_GENERATE_BIT(ug), .COUNTER_WRITE(cwr), .COUNTER_WRITE_DATA(cwd), .TRIGGER_FLAG_CLEAR(fclr),
        .INTERNAL_TRIGGER_ZERO(internal_trigger_zero), .INTERNAL_TRIGGER_ONE(src[1]), .INTERNAL_TRIGGER_TWO(src[2]),
        .INTERNAL_TRIGGER_THREE(src[3]), .CHANNEL1_INPUT(src[4]), .FILTERED_INPUT_ONE(src[5]),
        .FILTERED_INPUT_TWO(src[6]), .EXTERNAL_TRIGGER(src[7]), .COMPARE_REFERENCE_N(cref),
        .CAPTURE_COMPARE_EVENT(1'b0), .CORE_HALTED(halted), .DEBUG_FREEZE_BIT(freeze),
        .TRIGGER_OUTPUT(trg), .COUNTER_ENABLE_BIT(en), .COUNTER_RUN_SIGNAL(run), .TRIGGER_FLAG(flag),
        .UPDATE_EVENT(upd), .COUNTER(cnt));
    tms_master_model i_tms_master_model (.clk(clk), .rst_b(rst_b), .gate(m_gate), .fire(m_fire),
        .count(m_cnt), .trig(internal_trigger_zero), .busy(m_busy));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic err(input string msg);
        err_count++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    task automatic chk1(input logic got, input logic exp, input string msg);
        compares++;
        if (got !== exp) err(msg);
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) err(msg);
    endtask
    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi, input string msg);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) err(msg);
    endtask
    // One-cycle software strobes: enable set, enable clear, update, counter write, flag clear
    task automatic sw(input logic s, input logic cl, input logic u, input logic w, input logic f);
        @(posedge clk);
        {en_set, en_clr, ug, cwr, fclr} <= {s, cl, u, w, f};
        @(posedge clk);
        {en_set, en_clr, ug, cwr, fclr} <= 5'h00;
    endtask
    task automatic done(input string name);
        $display("Test %s finished", name);
    endtask
    // Cycles from a trigger rise on the external input to the enable bit
    task automatic lat(input logic m, output int d);
        sw(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        msb <= m;
        sm <= TMS_SM_TRIG;
        ts <= TMS_TS_EXT;
        src <= 8'h00;
        tick(3);
        src[7] <= 1'b1;
        d = 0;
        while (en !== 1'b1 && d < 20) begin
            tick(1);
            d++;
        end
        src[7] <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            err("run did not finish");
            wrap_up();
        end
    end
    initial begin
        tick(16);
        rst_b <= 1'b1;
        tick(2);
        chk16({11'h000, trg, en, run, flag, upd}, 16'h0000, "flags after reset");
        chk16(cnt, TMS_CNT_RST, "counter after reset");
        done("reset");
        for (int i = 0; i < 7; i++) begin
            sw(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
            {mos, cref, ts} <= {rows[i].mos, rows[i].cref, rows[i].ts};
            sm <= TMS_SM_TRIG;
            src <= 8'h00;
            tick(3);
            src[rows[i].ts] <= 1'b1;
            tick(4);
            chk1(en, 1'b1, "trigger start");
            chk1(flag, 1'b1, "trigger flag");
            chk1(trg, rows[i].exp, "trigger output");
        end
        done("table");
        sw(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(2);
        chk1(en, 1'b0, "enable clear");
        sm <= TMS_SM_EXTCLK;
        ts <= TMS_TS_INTERNAL_TRIGGER_ZERO;
        sw(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        sw(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        tick(2);
        m_cnt <= 8'h05;
        m_fire <= 1'b1;
        tick(1);
        m_fire <= 1'b0;
        for (int k = 0; k < 50 && m_busy; k++) tick(1);
        tick(3);
        chk16(cnt, 16'h0005, "external clock count");
        done("external clock");
        sm <= TMS_SM_OFF;
        mos <= TMS_MOS_UPD;
        arr <= 16'h0003;
        sw(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        nu = 0;
        for (int k = 0; k < 40; k++) begin
            tick(1);
            nu += (upd === 1'b1);
            chk1(trg, upd, "update on trigger output");
        end
        chk_rng(16'(nu), 16'h0009, 16'h000B, "update rate");
        done("update output");
        arr <= 16'hFFFF;
        psc <= 16'h0002;
        sm <= TMS_SM_GATED;
        cwd <= 16'h00E7;
        sw(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        sw(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        tick(6);
        chk16(cnt, 16'h00E7, "counter load holds with gate low");
        m_gate <= 1'b1;
        tick(30);
        m_gate <= 1'b0;
        tick(6);
        chk_rng(cnt, 16'h00F0, 16'h00F2, "gated count");
        c = cnt;
        tick(10);
        chk16(cnt, c, "gate low holds");
        sw(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        tick(2);
        chk16(cnt, 16'h0000, "update generate");
        done("gated");
        sm <= TMS_SM_OFF;
        psc <= 16'h0000;
        {halted, freeze} <= 2'b11;
        tick(3);
        c = cnt;
        tick(10);
        chk16(cnt, c, "debug freeze");
        freeze <= 1'b0;
        tick(3);
        c = cnt;
        tick(10);
        chk16(cnt, c + 16'h000A, "debug run");
        halted <= 1'b0;
        done("debug");
        lat(1'b0, d0);
        lat(1'b1, d1);
        chk1(en, 1'b1, "delayed start");
        chk16(16'(d1), 16'(d0 + TMS_MSM_DLY), "master/slave delay");
        done("master slave");
        msb <= 1'b0;
        sm <= TMS_SM_RESET;
        sw(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        tick(4);
        src[7] <= 1'b1;
        tick(2);
        chk16(cnt, TMS_CNT_RST, "trigger reset of counter");
        chk1(flag, 1'b1, "reset mode trigger flag");
        done("slave reset");
        sm <= TMS_SM_OFF;
        src <= 8'h00;
        rst_b <= 1'b0;
        tick(2);
        chk16({11'h000, trg, en, run, flag, upd}, 16'h0000, "flags in mid-run reset");
        chk16(cnt, TMS_CNT_RST, "counter in mid-run reset");
        rst_b <= 1'b1;
        tick(2);
        chk16({11'h000, trg, en, run, flag, upd}, 16'h0000, "flags after second reset");
        done("mid-run reset");
        wrap_up();
    end
endmodule

// ### tms_master_model.sv
// Model of a master timer feeding the slave's internal trigger line zero.
// Assumes its requests arrive on the rising clock edge.
`timescale 1ns/100ps
module tms_master_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic gate,
    input wire logic fire,
    input wire logic [7:0] count,
    output logic trig,
    output logic busy
);
    logic [7:0] left;
    logic pulse;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 8'h00;
            pulse <= 1'b0;
        end else begin
            pulse <= (left != 8'h00) && !pulse; // One-cycle update pulses with a gap
            if (fire) begin
                left <= count;
            end else if ((left != 8'h00) && !pulse) begin
                left <= left - 8'h01;
            end
        end
    end
    assign busy = (left != 8'h00) || fire;
    assign trig = pulse | gate; // Update pulses or gate level
endmodule

// ### tms_pkg.sv
// Constants for the timer master/slave synchronisation block.
// Assumes a single 40 MHz timer clock shared by all timers on the chip.
package tms_pkg;
    localparam int TMS_CLK_MHZ = 40;
    localparam int TMS_CNT_W = 16;
    localparam logic [15:0] TMS_CNT_RST = 16'h0000;
    localparam logic [15:0] TMS_PSC_RST = 16'h0000;
    localparam logic [15:0] TMS_ARR_RST = 16'hFFFF;
    // Master output selections
    localparam logic [2:0] TMS_MOS_UG = 3'h0;
    localparam logic [2:0] TMS_MOS_EN = 3'h1;
    localparam logic [2:0] TMS_MOS_UPD = 3'h2;
    localparam logic [2:0] TMS_MOS_CC = 3'h3;
    localparam logic [2:0] TMS_MOS_OC1 = 3'h4;
    // Trigger source selections
    localparam logic [2:0] TMS_TS_INTERNAL_TRIGGER_ZERO = 3'h0;
    localparam logic [2:0] TMS_TS_INTERNAL_TRIGGER_ONE = 3'h1;
    localparam logic [2:0] TMS_TS_ITR2 = 3'h2;
    localparam logic [2:0] TMS_TS_ITR3 = 3'h3;
    localparam logic [2:0] TMS_TS_CH1ED = 3'h4;
    localparam logic [2:0] TMS_TS_FP1 = 3'h5;
    localparam logic [2:0] TMS_TS_FP2 = 3'h6;
    localparam logic [2:0] TMS_TS_EXT = 3'h7;
    // Slave modes
    localparam logic [2:0] TMS_SM_OFF = 3'h0;
    localparam logic [2:0] TMS_SM_RESET = 3'h4;
    localparam logic [2:0] TMS_SM_GATED = 3'h5;
    localparam logic [2:0] TMS_SM_TRIG = 3'h6;
    localparam logic [2:0] TMS_SM_EXTCLK = 3'h7;
    // Master/slave alignment delay in timer clocks
    localparam int TMS_MSM_DLY = 1;
endpackage

// ### tms_prescaler.sv
// Prescaler: divides the timer clock into one-cycle counter-clock pulses.
// Assumes the caller gives the enable and the reinitialise strobe.
`timescale 1ns/100ps
module tms_prescaler
    import tms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic reinit,
    input wire logic [15:0] divide,
    output logic tick
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic next_tick;

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (reinit) begin
            next_count = 16'h0000;
        end else if (run) begin
            if (count >= divide) begin
                next_count = 16'h0000;
                next_tick = 1'b1;
            end else begin
                next_count = count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= TMS_PSC_RST;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule

// ### tms_timer_sync.sv
// Timer counter with master/slave synchronisation: trigger output selection,
// trigger input selection and slave modes. Inputs are synchronous to CORE_CLK;
// trigger inputs from other timers come straight from their flops.
// Behaviour
// - Master drives reset, start, stop or clock
// - Select 010 pulses trigger on update
// - Select 000 takes internal trigger zero
// - Mode 111 counts trigger rising edges
// - Select 1xx routes compare reference out
// - Select 100 outputs compare one reference
// - Mode 101 counts only while trigger high
// - Gating stops the prescaler, not the enable bit
// - Trigger start keeps counter and prescaler
// - Update generate reinitialises counter, prescaler
// - Counter write loads value directly
// - Mode 110 trigger sets enable bit
// - Select 001 outputs counter run signal
// - Source 100 uses channel one edges
// - Master/slave delays prescaler after enable
// - Starting trigger sets trigger flag
// - Debug halt freezes when freeze bit set
// - Master/slave bit delays trigger effect
// - Trigger source encoding zero to seven
`timescale 1ns/100ps
module tms_timer_sync
    import tms_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic [2:0] MASTER_OUTPUT_SELECT,
    input wire logic [2:0] TRIGGER_SOURCE_SELECT,
    input wire logic [2:0] SLAVE_MODE_SELECT,
    input wire logic MASTER_SLAVE_BIT,
    input wire logic [15:0] PRESCALE_DIV,
    input wire logic [15:0] AUTO_RELOAD,
    input wire logic COUNTER_ENABLE_SET,
    input wire logic COUNTER_ENABLE_CLEAR,
    input wire logic UPDATE_GENERATE_BIT,
    input wire logic COUNTER_WRITE,
    input wire logic [15:0] COUNTER_WRITE_DATA,
    input wire logic TRIGGER_FLAG_CLEAR,
    input wire logic INTERNAL_TRIGGER_ZERO,
    input wire logic INTERNAL_TRIGGER_ONE,
    input wire logic INTERNAL_TRIGGER_TWO,
    input wire logic INTERNAL_TRIGGER_THREE,
    input wire logic CHANNEL1_INPUT,
    input wire logic FILTERED_INPUT_ONE,
    input wire logic FILTERED_INPUT_TWO,
    input wire logic EXTERNAL_TRIGGER,
    input wire logic [3:0] COMPARE_REFERENCE_N,
    input wire logic CAPTURE_COMPARE_EVENT,
    input wire logic CORE_HALTED,
    input wire logic DEBUG_FREEZE_BIT,
    output logic TRIGGER_OUTPUT,
    output logic COUNTER_ENABLE_BIT,
    output logic COUNTER_RUN_SIGNAL,
    output logic TRIGGER_FLAG,
    output logic UPDATE_EVENT,
    output logic [15:0] COUNTER
);
    logic trgi_prev;
    logic ch1_prev;
    logic trg_edge_q;
    logic trg_level_q;
    logic next_trgi_prev;
    logic next_ch1_prev;
    logic next_trg_edge_q;
    logic next_trg_level_q;
    logic trgi;
    logic trg_rise;
    logic trg_edge;
    logic trg_level;
    logic counter_enable_bit;
    logic next_cen;
    logic flag;
    logic next_flag;
    logic run_d;
    logic next_run_d;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic upd;
    logic next_upd;
    logic trigger_output;
    logic next_trigger_output;
    logic run_q;
    logic next_run_q;
    logic frozen;
    logic gated_run;
    logic psc_run;
    logic psc_reinit;
    logic psc_tick;
    logic cnt_step;
    logic slave_reset;
    logic gate_prev;
    logic next_gate_prev;

    // Trigger input select; CH1 edge detector gives a pulse per change
    always_comb begin
        case (TRIGGER_SOURCE_SELECT)
            TMS_TS_INTERNAL_TRIGGER_ZERO: trgi = INTERNAL_TRIGGER_ZERO;
            TMS_TS_INTERNAL_TRIGGER_ONE: trgi = INTERNAL_TRIGGER_ONE;
            TMS_TS_ITR2: trgi = INTERNAL_TRIGGER_TWO;
            TMS_TS_ITR3: trgi = INTERNAL_TRIGGER_THREE;
            TMS_TS_CH1ED: trgi = CHANNEL1_INPUT ^ ch1_prev;
            TMS_TS_FP1: trgi = FILTERED_INPUT_ONE;
            TMS_TS_FP2: trgi = FILTERED_INPUT_TWO;
            TMS_TS_EXT: trgi = EXTERNAL_TRIGGER;
            default: trgi = 1'b0;
        endcase
    end

    // Edge/level path, delayed one clock when in master/slave mode
    always_comb begin
        next_trgi_prev = trgi;
        next_ch1_prev = CHANNEL1_INPUT;
        trg_rise = trgi & ~trgi_prev;
        next_trg_edge_q = trg_rise;
        next_trg_level_q = trgi;
        trg_edge = MASTER_SLAVE_BIT ? trg_edge_q : trg_rise;
        trg_level = MASTER_SLAVE_BIT ? trg_level_q : trgi;
        // Level as the slave logic saw it last cycle, in either timing
        next_gate_prev = trg_level;
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            trgi_prev <= 1'b0;
            ch1_prev <= 1'b0;
            trg_edge_q <= 1'b0;
            trg_level_q <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            trgi_prev <= next_trgi_prev;
            ch1_prev <= next_ch1_prev;
            trg_edge_q <= next_trg_edge_q;
            trg_level_q <= next_trg_level_q;
            gate_prev <= next_gate_prev;
        end
    end

    assign frozen = CORE_HALTED & DEBUG_FREEZE_BIT;
    assign slave_reset = (SLAVE_MODE_SELECT == TMS_SM_RESET) & trg_edge;
    // Gated mode only qualifies the run signal, which also stops the prescaler
    assign gated_run = (SLAVE_MODE_SELECT != TMS_SM_GATED) | trg_level;

    // Enable bit, trigger-mode set and trigger flag
    always_comb begin
        next_cen = counter_enable_bit;
        if (COUNTER_ENABLE_CLEAR) begin
            next_cen = 1'b0;
        end
        if (COUNTER_ENABLE_SET) begin
            next_cen = 1'b1;
        end
        if ((SLAVE_MODE_SELECT == TMS_SM_TRIG) & trg_edge) begin
            next_cen = 1'b1;
        end
        next_flag = flag & ~TRIGGER_FLAG_CLEAR;
        // Set wins over clear
        if (trg_edge & (SLAVE_MODE_SELECT != TMS_SM_OFF) & (SLAVE_MODE_SELECT != TMS_SM_GATED)) begin
            next_flag = 1'b1;
        end
        // Gated mode marks both the start and the stop of counting
        if ((SLAVE_MODE_SELECT == TMS_SM_GATED) & (trg_level != gate_prev)) begin
            next_flag = 1'b1;
        end
    end

    // Run signal; in master/slave mode the prescaler enable lags one clock
    always_comb begin
        next_run_q = counter_enable_bit & gated_run;
        next_run_d = run_q;
    end

    assign psc_run = (MASTER_SLAVE_BIT ? run_d & run_q : run_q) & ~frozen;
    assign psc_reinit = UPDATE_GENERATE_BIT | slave_reset;

    tms_prescaler u_psc (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .run(psc_run & (SLAVE_MODE_SELECT != TMS_SM_EXTCLK)),
        .reinit(psc_reinit),
        .divide(PRESCALE_DIV),
        .tick(psc_tick)
    );

    // External clock mode 1 counts trigger rising edges
    assign cnt_step = (SLAVE_MODE_SELECT == TMS_SM_EXTCLK) ? (trg_edge & counter_enable_bit & ~frozen) : psc_tick;

    // Counter with reload, software load and reinitialise
    always_comb begin
        next_cnt = cnt;
        next_upd = 1'b0;
        if (psc_reinit) begin
            next_cnt = TMS_CNT_RST;
            next_upd = 1'b1;
        end else if (COUNTER_WRITE) begin
            next_cnt = COUNTER_WRITE_DATA;
        end else if (cnt_step) begin
            if (cnt >= AUTO_RELOAD) begin
                next_cnt = TMS_CNT_RST;
                next_upd = 1'b1;
            end else begin
                next_cnt = cnt + 16'h0001;
            end
        end
    end

    // Trigger output selection
    always_comb begin
        case (MASTER_OUTPUT_SELECT)
            TMS_MOS_UG: next_trigger_output = UPDATE_GENERATE_BIT;
            TMS_MOS_EN: next_trigger_output = next_run_q;
            TMS_MOS_UPD: next_trigger_output = next_upd;
            TMS_MOS_CC: next_trigger_output = CAPTURE_COMPARE_EVENT;
            TMS_MOS_OC1: next_trigger_output = COMPARE_REFERENCE_N[0];
            3'h5: next_trigger_output = COMPARE_REFERENCE_N[1];
            3'h6: next_trigger_output = COMPARE_REFERENCE_N[2];
            3'h7: next_trigger_output = COMPARE_REFERENCE_N[3];
            default: next_trigger_output = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            counter_enable_bit <= 1'b0;
            flag <= 1'b0;
            run_q <= 1'b0;
            run_d <= 1'b0;
            cnt <= TMS_CNT_RST;
            upd <= 1'b0;
            trigger_output <= 1'b0;
        end else begin
            counter_enable_bit <= next_cen;
            flag <= next_flag;
            run_q <= next_run_q;
            run_d <= next_run_d;
            cnt <= next_cnt;
            upd <= next_upd;
            trigger_output <= next_trigger_output;
        end
    end

    assign TRIGGER_OUTPUT = trigger_output;
    assign COUNTER_ENABLE_BIT = counter_enable_bit;
    assign COUNTER_RUN_SIGNAL = run_q;
    assign TRIGGER_FLAG = flag;
    assign UPDATE_EVENT = upd;
    assign COUNTER = cnt;

    AST_UPD_TRIGGER_OUTPUT: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (MASTER_OUTPUT_SELECT == TMS_MOS_UPD) && next_upd |=> TRIGGER_OUTPUT)
        else $error("update did not pulse trigger output");
    AST_UG_CLEAR: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        UPDATE_GENERATE_BIT |=> COUNTER == 16'h0000)
        else $error("update generate did not clear counter");
    AST_CNT_LOAD: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        COUNTER_WRITE && !UPDATE_GENERATE_BIT && !slave_reset |=> COUNTER == $past(COUNTER_WRITE_DATA))
        else $error("counter write not loaded");
    AST_TRIG_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (SLAVE_MODE_SELECT == TMS_SM_TRIG) && trg_edge |=> COUNTER_ENABLE_BIT && TRIGGER_FLAG)
        else $error("trigger mode did not set enable and flag");
    AST_OC1_OUT: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        MASTER_OUTPUT_SELECT == TMS_MOS_OC1 |=> TRIGGER_OUTPUT == $past(COMPARE_REFERENCE_N[0]))
        else $error("compare reference not on trigger output");
    AST_GATE_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (SLAVE_MODE_SELECT == TMS_SM_GATED) && !run_q
        ##1 (SLAVE_MODE_SELECT == TMS_SM_GATED) && !psc_reinit && !COUNTER_WRITE |=> $stable(COUNTER))
        else $error("gated counter moved while gate low");
    AST_FREEZE: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        frozen ##1 frozen && !psc_reinit && !COUNTER_WRITE |=> $stable(COUNTER))
        else $error("counter moved while frozen");
    AST_EXT_STEP: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (SLAVE_MODE_SELECT == TMS_SM_EXTCLK) && trg_edge && counter_enable_bit && !frozen && !psc_reinit
        && !COUNTER_WRITE && cnt < AUTO_RELOAD |=> COUNTER == $past(cnt) + 16'h0001)
        else $error("external clock edge did not advance counter");
    AST_EN_TRIGGER_OUTPUT: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        MASTER_OUTPUT_SELECT == TMS_MOS_EN |=> TRIGGER_OUTPUT == COUNTER_RUN_SIGNAL)
        else $error("run signal not on trigger output");
    AST_MSM_PSC: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        MASTER_SLAVE_BIT && !run_q ##1 MASTER_SLAVE_BIT && run_q |-> !psc_run)
        else $error("prescaler started with the enable in master/slave mode");
    AST_MSM_EDGE: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        MASTER_SLAVE_BIT && trg_rise ##1 MASTER_SLAVE_BIT |-> trg_edge)
        else $error("delayed trigger edge missing");
    AST_GATED_RUN: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (SLAVE_MODE_SELECT == TMS_SM_GATED) && !trg_level |=> !COUNTER_RUN_SIGNAL)
        else $error("gated counter ran with gate low");
    AST_TRIG_KEEP: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (SLAVE_MODE_SELECT == TMS_SM_TRIG) && trg_edge && !psc_reinit && !COUNTER_WRITE && !cnt_step
        |=> $stable(COUNTER))
        else $error("trigger start changed the counter");
    AST_FLAG_SET: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        trg_edge && (SLAVE_MODE_SELECT == TMS_SM_TRIG || SLAVE_MODE_SELECT == TMS_SM_RESET) |=> TRIGGER_FLAG)
        else $error("trigger event did not set flag");
    AST_RESET_MODE: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (SLAVE_MODE_SELECT == TMS_SM_RESET) && trg_edge |=> COUNTER == TMS_CNT_RST && UPDATE_EVENT)
        else $error("reset mode did not clear counter");
    AST_CH1_EDGE: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (TRIGGER_SOURCE_SELECT == TMS_TS_CH1ED) && (CHANNEL1_INPUT != ch1_prev) |-> trgi)
        else $error("channel one change gave no trigger");
endmodule
